// ===== src/i2c_master_pkg.sv
// Behaviour
// RULE1: Generator reloads from low seven reload bits
// RULE2: Generator decrements on second and fourth phase
// RULE3: Reload waits until SCL actually samples high
// RULE4: Buffer write starts generator, stops after acknowledge
// RULE5: Start drives SDA low after one period
// RULE6: Second period ends start, clears request
// RULE7: Line low during start flags bus collision
// RULE8: Buffer write during start sets write collision
// RULE9: Control writes ignored while sequence runs
// RULE10: Repeated start request accepted only when idle
// RULE11: Repeated start walks SCL, SDA through periods
// RULE12: Start seen on lines; interrupt after timeout
// RULE13: Repeated start collision on SDA or SCL
// RULE14: Buffer write during repeated start sets collision
// RULE15: Buffer write sets full, shifts bits out
// RULE16: Eighth falling edge clears full, releases SDA
// RULE17: Ninth falling edge samples acknowledge into status
// RULE18: After ninth clock interrupt, hold SCL low
// RULE19: Write while shifting discarded, collision flag sticky
// RULE20: First byte is address plus direction bit
// RULE21: Software sends address after repeated start interrupt
// RULE22: Software sequences start, bytes, then stop
// RULE23: Stop sequence releases SCL then SDA, interrupts
// RULE24: Lines are only pulled low or released
package i2c_master_pkg;

    // ****************************************************
    // Register map
    // ****************************************************
    localparam int          ADDR_W       = 5;
    localparam logic [4:0]  OFS_BAUD     = 5'h00;
    localparam logic [4:0]  OFS_BUF      = 5'h04;
    localparam logic [4:0]  OFS_CTRL2    = 5'h08;
    localparam logic [4:0]  OFS_STAT     = 5'h0c;
    localparam logic [4:0]  OFS_FLAG     = 5'h10;

    localparam int          C2_START     = 0;
    localparam int          C2_RSTART    = 1;
    localparam int          C2_STOP      = 2;
    localparam int          C2_ACK_STATUS   = 6;
    localparam int          ST_BF        = 0;
    localparam int          ST_START     = 3;
    localparam int          ST_STOP      = 4;
    localparam int          FL_WRITE_COLLISION_FLAG      = 0;
    localparam int          FL_SIF       = 1;
    localparam int          FL_BCL       = 2;

    // ****************************************************
    // Baud generator and shifter
    // ****************************************************
    localparam int          RELOAD_W     = 7;
    localparam logic [1:0]  PH_Q2        = 2'h1;
    localparam logic [1:0]  PH_Q4        = 2'h3;
    localparam logic [3:0]  BIT_LAST     = 4'h7;
    localparam logic [3:0]  BIT_ACK      = 4'h8;

    typedef enum logic [3:0] {
        S_IDLE      = 4'h0,
        S_ST_WAIT   = 4'h1,
        S_ST_HOLD   = 4'h2,
        S_RS_SCLLO  = 4'h3,
        S_RS_SDAREL = 4'h4,
        S_RS_SCLREL = 4'h5,
        S_RS_HIGH   = 4'h6,
        S_RS_SDALO  = 4'h7,
        S_TX_LOW    = 4'h8,
        S_TX_RISE   = 4'h9,
        S_TX_HIGH   = 4'ha,
        S_SP_SDALO  = 4'hb,
        S_SP_RUN    = 4'hc,
        S_SP_SCLREL = 4'hd,
        S_SP_SDAREL = 4'he,
        S_SP_DONE   = 4'hf
    } state_e;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [31:0]       writedata;
        logic [3:0]        byteenable;
    } avs_req_s;

endpackage : i2c_master_pkg

// ===== src/i2c_master_start_tx_brg.sv
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module i2c_master_start_tx_brg
    import i2c_master_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire avs_req_s    AVS_REQ,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE,
    input  wire logic        SCL_IN,
    output logic             SCL_OUT,
    output logic             SCL_OE
);

    // ****************************************************
    // State
    // ****************************************************
    typedef struct packed {
        state_e              state;
        logic                wait_req;
        logic [31:0]         rdata;
        logic [2:0]          sda_sync;
        logic [2:0]          scl_sync;
        logic                sda_lvl;
        logic                scl_lvl;
        logic [1:0]          phase;
        logic [RELOAD_W-1:0] brg_cnt;
        logic                brg_run;
        logic [7:0]          baud_reload_reg;
        logic [7:0]          shift_buffer;
        logic [7:0]          shift_register;
        logic [3:0]          bit_no;
        logic                start_request;
        logic                repeated_start_request;
        logic                stop_request;
        logic                ack_status;
        logic                buffer_full;
        logic                start_seen;
        logic                stop_seen;
        logic                write_collision_flag;
        logic                serial_interrupt_flag;
        logic                bus_collision_flag;
        logic                sda_oe;
        logic                scl_oe;
        logic                line_level;
    } core_s;

    core_s       st;
    core_s       next_st;
    logic        tick;
    logic        expire;
    logic        load;
    logic        abort;
    logic        wr_go;
    logic        sda_ok;
    logic        scl_ok;
    logic        busy;
    logic [7:0]  ctrl2_view;
    logic [7:0]  stat_view;
    logic [7:0]  flag_view;

    // ****************************************************
    // Next state
    // ****************************************************
    always_comb begin
        next_st = st;
        tick    = (st.phase == PH_Q2) || (st.phase == PH_Q4); // RULE2
        expire  = st.brg_run && (st.brg_cnt == '0);
        load    = 1'b0;
        abort   = 1'b0;
        busy    = (st.state != S_IDLE) || st.start_request
                  || st.repeated_start_request || st.stop_request;
        wr_go   = AVS_REQ.write && !st.wait_req && AVS_REQ.byteenable[0];
        sda_ok  = st.sda_sync[1] == st.sda_sync[2];
        scl_ok  = st.scl_sync[1] == st.scl_sync[2];
        ctrl2_view = '0;
        ctrl2_view[C2_START]   = st.start_request;
        ctrl2_view[C2_RSTART]  = st.repeated_start_request;
        ctrl2_view[C2_STOP]    = st.stop_request;
        ctrl2_view[C2_ACK_STATUS] = st.ack_status;
        stat_view = '0;
        stat_view[ST_BF]       = st.buffer_full;
        stat_view[ST_START]    = st.start_seen;
        stat_view[ST_STOP]     = st.stop_seen;
        flag_view = '0;
        flag_view[FL_WRITE_COLLISION_FLAG]     = st.write_collision_flag;
        flag_view[FL_SIF]      = st.serial_interrupt_flag;
        flag_view[FL_BCL]      = st.bus_collision_flag;

        // Line sampling, three stages, agreement of last two
        next_st.sda_sync = {st.sda_sync[1:0], SDA_IN};
        next_st.scl_sync = {st.scl_sync[1:0], SCL_IN};
        if (sda_ok) begin
            next_st.sda_lvl = st.sda_sync[2];
        end
        if (scl_ok) begin
            next_st.scl_lvl = st.scl_sync[2];
        end

        // Start and stop detection on the lines
        if (sda_ok && st.scl_lvl && (st.sda_lvl != st.sda_sync[2])) begin
            if (!st.sda_sync[2]) begin
                next_st.start_seen = 1'b1; // RULE12
                next_st.stop_seen  = 1'b0;
            end else begin
                next_st.stop_seen  = 1'b1;
                next_st.start_seen = 1'b0;
            end
        end

        // Baud generator countdown
        next_st.phase = 2'(st.phase + 2'h1);
        if (tick && st.brg_cnt != '0) begin
            next_st.brg_cnt = st.brg_cnt - 7'h01; // RULE2
        end
        if (expire) begin
            next_st.brg_run = 1'b0; // RULE1
        end

        // Bus slave
        next_st.wait_req = 1'b1;
        if ((AVS_REQ.read || AVS_REQ.write) && st.wait_req) begin
            next_st.wait_req = 1'b0;
            next_st.rdata    = '0;
            case (AVS_REQ.address)
                OFS_BAUD:  next_st.rdata[7:0] = st.baud_reload_reg;
                OFS_BUF:   next_st.rdata[7:0] = st.shift_buffer;
                OFS_CTRL2: next_st.rdata[7:0] = ctrl2_view;
                OFS_STAT:  next_st.rdata[7:0] = stat_view;
                OFS_FLAG:  next_st.rdata[7:0] = flag_view;
                default:   next_st.rdata      = '0;
            endcase
        end
        if (wr_go) begin
            case (AVS_REQ.address)
                OFS_BAUD: begin
                    next_st.baud_reload_reg = AVS_REQ.writedata[7:0];
                end
                OFS_BUF: begin
                    if (busy) begin
                        next_st.write_collision_flag = 1'b1; // RULE8 RULE14 RULE19
                    end else begin
                        next_st.shift_buffer   = AVS_REQ.writedata[7:0];
                        next_st.shift_register = AVS_REQ.writedata[7:0];
                        next_st.buffer_full    = 1'b1; // RULE15
                        next_st.bit_no         = '0;
                        next_st.scl_oe         = 1'b1;
                        next_st.state          = S_TX_LOW;
                        load                   = 1'b1; // RULE4
                    end
                end
                OFS_CTRL2: begin
                    if (!busy) begin // RULE9 RULE10
                        next_st.start_request          = AVS_REQ.writedata[C2_START];
                        next_st.repeated_start_request = AVS_REQ.writedata[C2_RSTART];
                        next_st.stop_request           = AVS_REQ.writedata[C2_STOP];
                    end
                end
                OFS_FLAG: begin
                    if (AVS_REQ.writedata[FL_WRITE_COLLISION_FLAG]) begin
                        next_st.write_collision_flag = 1'b0; // RULE19
                    end
                    if (AVS_REQ.writedata[FL_SIF]) begin
                        next_st.serial_interrupt_flag = 1'b0;
                    end
                    if (AVS_REQ.writedata[FL_BCL]) begin
                        next_st.bus_collision_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Sequencer
        case (st.state)
            S_IDLE: begin
                if (st.start_request) begin
                    if (st.sda_lvl && st.scl_lvl) begin
                        load          = 1'b1; // RULE5
                        next_st.state = S_ST_WAIT;
                    end else begin
                        abort = 1'b1; // RULE7
                    end
                end else if (st.repeated_start_request) begin
                    next_st.scl_oe = 1'b1; // RULE11
                    next_st.state  = S_RS_SCLLO;
                end else if (st.stop_request) begin
                    next_st.sda_oe = 1'b1; // RULE23
                    next_st.state  = S_SP_SDALO;
                end
            end
            S_ST_WAIT: begin
                if (!st.scl_lvl) begin
                    abort = 1'b1; // RULE7
                end else if (expire) begin
                    if (st.sda_lvl) begin
                        next_st.sda_oe     = 1'b1; // RULE5 RULE24
                        next_st.start_seen = 1'b1;
                        load               = 1'b1; // RULE6
                        next_st.state      = S_ST_HOLD;
                    end else begin
                        abort = 1'b1;
                    end
                end
            end
            S_ST_HOLD: begin
                if (expire) begin
                    next_st.start_request         = 1'b0; // RULE6
                    next_st.serial_interrupt_flag = 1'b1;
                    next_st.state                 = S_IDLE;
                end
            end
            S_RS_SCLLO: begin
                if (!st.scl_lvl) begin
                    next_st.sda_oe = 1'b0; // RULE11
                    load           = 1'b1;
                    next_st.state  = S_RS_SDAREL;
                end
            end
            S_RS_SDAREL: begin
                if (expire) begin
                    if (st.sda_lvl) begin
                        next_st.scl_oe = 1'b0; // RULE11
                        next_st.state  = S_RS_SCLREL;
                    end else begin
                        abort = 1'b1; // RULE13
                    end
                end
            end
            S_RS_SCLREL: begin
                if (st.scl_lvl) begin
                    if (!st.sda_lvl) begin
                        abort = 1'b1; // RULE13
                    end else begin
                        load          = 1'b1; // RULE3
                        next_st.state = S_RS_HIGH;
                    end
                end
            end
            S_RS_HIGH: begin
                if (!st.scl_lvl) begin
                    abort = 1'b1; // RULE13
                end else if (expire) begin
                    next_st.sda_oe = 1'b1; // RULE11
                    load           = 1'b1;
                    next_st.state  = S_RS_SDALO;
                end
            end
            S_RS_SDALO: begin
                if (expire) begin
                    next_st.repeated_start_request = 1'b0; // RULE11
                    next_st.serial_interrupt_flag  = 1'b1; // RULE12
                    next_st.state                  = S_IDLE;
                end
            end
            S_TX_LOW: begin
                if (!st.scl_lvl) begin
                    next_st.sda_oe = (st.bit_no != BIT_ACK) && !st.shift_register[7]; // RULE16
                end
                if (expire) begin
                    next_st.scl_oe = 1'b0; // RULE15
                    next_st.state  = S_TX_RISE;
                end
            end
            S_TX_RISE: begin
                if (st.scl_lvl) begin
                    load          = 1'b1; // RULE3
                    next_st.state = S_TX_HIGH;
                end
            end
            S_TX_HIGH: begin
                if (expire) begin
                    next_st.scl_oe = 1'b1;
                    if (st.bit_no == BIT_ACK) begin
                        next_st.ack_status            = st.sda_lvl; // RULE17
                        next_st.serial_interrupt_flag = 1'b1; // RULE18
                        next_st.state                 = S_IDLE; // RULE4
                    end else begin
                        next_st.bit_no         = 4'(st.bit_no + 4'h1);
                        next_st.shift_register = {st.shift_register[6:0], 1'b0};
                        if (st.bit_no == BIT_LAST) begin
                            next_st.buffer_full = 1'b0; // RULE16
                        end
                        load          = 1'b1;
                        next_st.state = S_TX_LOW;
                    end
                end
            end
            S_SP_SDALO: begin
                if (!st.sda_lvl) begin
                    load          = 1'b1; // RULE23
                    next_st.state = S_SP_RUN;
                end
            end
            S_SP_RUN: begin
                if (expire) begin
                    next_st.scl_oe = 1'b0; // RULE23
                    next_st.state  = S_SP_SCLREL;
                end
            end
            S_SP_SCLREL: begin
                if (st.scl_lvl) begin
                    load          = 1'b1; // RULE3
                    next_st.state = S_SP_SDAREL;
                end
            end
            S_SP_SDAREL: begin
                if (expire) begin
                    next_st.sda_oe = 1'b0; // RULE23
                    load           = 1'b1;
                    next_st.state  = S_SP_DONE;
                end
            end
            S_SP_DONE: begin
                if (expire) begin
                    next_st.stop_seen             = 1'b1;
                    next_st.stop_request          = 1'b0; // RULE23
                    next_st.serial_interrupt_flag = 1'b1;
                    next_st.state                 = S_IDLE;
                end
            end
            default: begin
                next_st.state = S_IDLE;
            end
        endcase

        if (load) begin
            next_st.brg_cnt = st.baud_reload_reg[RELOAD_W-1:0]; // RULE1
            next_st.brg_run = 1'b1;
        end
        if (abort) begin
            next_st.bus_collision_flag     = 1'b1; // RULE7 RULE13
            next_st.start_request          = 1'b0;
            next_st.repeated_start_request = 1'b0;
            next_st.sda_oe                 = 1'b0;
            next_st.scl_oe                 = 1'b0;
            next_st.brg_run                = 1'b0;
            next_st.state                  = S_IDLE;
        end
        next_st.line_level = 1'b0; // RULE24
    end

    // ****************************************************
    // Registers
    // ****************************************************
    always_ff @(posedge CLK) begin
        if (SRST) begin
            st          <= '0;
            st.wait_req <= 1'b1;
            st.sda_lvl  <= 1'b1;
            st.scl_lvl  <= 1'b1;
            st.sda_sync <= 3'h7;
            st.scl_sync <= 3'h7;
        end else begin
            st <= next_st;
        end
    end

    assign AVS_READDATA    = st.rdata;
    assign AVS_WAITREQUEST = st.wait_req;
    assign SDA_OUT         = st.line_level;
    assign SCL_OUT         = st.line_level;
    assign SDA_OE          = st.sda_oe;
    assign SCL_OE          = st.scl_oe;

endmodule : i2c_master_start_tx_brg

// ===== tb/i2c_master_monitor.sv
`timescale 1ns/1ps
module i2c_master_monitor
    import i2c_master_pkg::*;
(
    input wire logic        CLK,
    input wire logic        SRST,
    input wire avs_req_s    AVS_REQ,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    input wire logic        SDA_IN,
    input wire logic        SDA_OUT,
    input wire logic        SDA_OE,
    input wire logic        SCL_IN,
    input wire logic        SCL_OUT,
    input wire logic        SCL_OE
);
    logic [6:0] reload;
    logic [3:0] cnt;
    logic       act;
    logic       scl_oe_q;
    logic [7:0] hi;
    logic       wr_ok;
    logic       free;
    assign wr_ok = AVS_REQ.write && !AVS_WAITREQUEST && AVS_REQ.byteenable[0];
    assign free  = !act || cnt == 4'h9;
    // ********************************
    // Byte framing tracker
    // ********************************
    always_ff @(posedge CLK) begin
        scl_oe_q <= SCL_OE;
        if (SRST) begin
            reload <= 7'h00;
            cnt    <= 4'h0;
            act    <= 1'b0;
            hi     <= 8'h00;
        end else begin
            hi <= SCL_OE ? 8'h00 : hi + {7'h00, SCL_IN};
            if (wr_ok && AVS_REQ.address == OFS_BAUD) begin
                reload <= AVS_REQ.writedata[6:0];
            end
            if (scl_oe_q && !SCL_OE && cnt != 4'h9) begin
                cnt <= cnt + 4'h1;
            end
            if (wr_ok && free && AVS_REQ.address == OFS_CTRL2) begin
                act <= 1'b0;
            end
            if (wr_ok && free && AVS_REQ.address == OFS_BUF && (SDA_OE || SCL_OE)) begin
                act <= 1'b1;
                cnt <= 4'h0;
            end
        end
    end
    // ********************************
    // Properties
    // ********************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    sequence s_bus_reply;
        !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endsequence
    sequence s_scl_free;
        !SCL_OE [*4];
    endsequence
    a_lines_low: assert property (!SDA_OUT && !SCL_OUT)
        else $error("Line driven high");
    a_bus_reply: assert property ((AVS_REQ.read || AVS_REQ.write) && AVS_WAITREQUEST
        |=> s_bus_reply) else $error("Bus answer late");
    a_bus_quiet: assert property (!(AVS_REQ.read || AVS_REQ.write) && AVS_WAITREQUEST
        |=> AVS_WAITREQUEST) else $error("Answer without request");
    a_start_high: assert property ($rose(SDA_OE) && !SCL_OE |-> SCL_IN)
        else $error("Start edge with clock low");
    a_stop_release: assert property ($fell(SDA_OE) && !SCL_OE |=> s_scl_free)
        else $error("Clock pulled after stop");
    a_tx_stable: assert property (act && cnt < 4'h9 && !SCL_OE
        |=> SCL_OE || $stable(SDA_OE)) else $error("Data moved in high");
    a_data_hold: assert property (act && $rose(SCL_OE) |-> $stable(SDA_OE))
        else $error("Data moved with clock fall");
    a_high_time: assert property (act && cnt != 4'h0 && !scl_oe_q && SCL_OE
        |-> hi >= {reload, 1'b0}) else $error("High phase short");
    a_ack_free: assert property (act && cnt == 4'h8 && !SCL_OE && scl_oe_q
        |-> !SDA_OE) else $error("Data held in ack slot");
    a_suspend_hold: assert property (act && cnt == 4'h9 && SCL_OE && !AVS_REQ.write
        |=> SCL_OE) else $error("Clock freed while suspended");
endmodule : i2c_master_monitor

bind i2c_master_start_tx_brg i2c_master_monitor u_monitor (
    .CLK(CLK), .SRST(SRST), .AVS_REQ(AVS_REQ), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE));

// ===== tb/i2c_master_start_tx_brg_test.sv
`timescale 1ns/1ps
module i2c_master_start_tx_brg_test;
    import i2c_master_pkg::*;
    logic        CLK;
    logic        SRST;
    avs_req_s    req;
    logic [31:0] rdata;
    logic        wait_req;
    logic        sda_out;
    logic        sda_oe;
    logic        scl_out;
    logic        scl_oe;
    logic        sda_pull;
    logic        scl_pull;
    logic        ack_en;
    logic        stretch;
    logic        jam_scl;
    logic [7:0]  got;
    logic [31:0] v;
    logic [7:0]  exp_q[$];
    int          miscompares;
    int          checked;
    wire         sda = !(sda_oe || sda_pull);
    wire         scl = !(scl_oe || scl_pull || jam_scl);

    i2c_master_start_tx_brg DUT (.CLK(CLK), .SRST(SRST), .AVS_REQ(req),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .SCL_IN(scl), .SCL_OUT(scl_out), .SCL_OE(scl_oe));
    i2c_slave_model PEER (.clk(CLK), .scl(scl), .sda(sda), .ack_en(ack_en),
        .stretch(stretch), .sda_pull(sda_pull), .scl_pull(scl_pull), .got(got));

    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    // ********************************
    // Bus and check tasks
    // ********************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic acc(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        req <= '{read: !wr, write: wr, address: a, writedata: {24'h0, d}, byteenable: 4'hf};
        do begin
            @(posedge CLK);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        v = rdata;
        req.read  <= 1'b0;
        req.write <= 1'b0;
        chk(wait_req, 1'b0);
    endtask : acc
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        acc(1'b0, a, 8'h00);
        chk(v, e);
    endtask : rd
    task automatic wait_flag(input logic [7:0] m);
        int n;
        n = 0;
        do begin
            acc(1'b0, OFS_FLAG, 8'h00);
            n++;
        end while ((v[7:0] & m) == 8'h00 && n < 600);
        chk(v[7:0] & m, m);
    endtask : wait_flag
    task automatic send(input logic [7:0] b, input logic ack);
        ack_en <= ack;
        exp_q.push_back(b);
        acc(1'b1, OFS_BUF, b);
        acc(1'b0, OFS_STAT, 8'h00);
        chk(v[ST_BF], 1'b1);
        acc(1'b1, OFS_BUF, ~b);
        acc(1'b1, OFS_CTRL2, 8'h02);
        wait_flag(8'h02);
        rd(OFS_FLAG, 32'h3);
        acc(1'b1, OFS_FLAG, 8'h07);
        rd(OFS_BUF, {24'h0, b});
        rd(OFS_CTRL2, {25'h0, !ack, 6'h0});
        acc(1'b0, OFS_STAT, 8'h00);
        chk(v[ST_BF], 1'b0);
        chk(scl_oe, 1'b1);
        chk(got, exp_q.pop_front());
    endtask : send
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end
    // ********************************
    // Main sequence
    // ********************************
    initial begin
        int         i;
        logic [7:0] b;
        SRST        = 1'b1;
        req         = '0;
        ack_en      = 1'b1;
        stretch     = 1'b0;
        jam_scl     = 1'b0;
        miscompares = 0;
        checked     = 0;
        v = $urandom(77804);
        repeat (12) @(posedge CLK);
        SRST <= 1'b0;
        for (i = 0; i <= 20; i += 4) rd(i[4:0], 32'h0);
        acc(1'b1, 5'h14, 8'hff);
        rd(5'h14, 32'h0);
        acc(1'b1, OFS_BAUD, 8'h83);
        rd(OFS_BAUD, 32'h83);
        acc(1'b1, OFS_CTRL2, 8'h01);
        acc(1'b1, OFS_BUF, 8'h5a);
        acc(1'b1, OFS_CTRL2, 8'h04);
        wait_flag(8'h02);
        rd(OFS_FLAG, 32'h3);
        rd(OFS_CTRL2, 32'h0);
        rd(OFS_BUF, 32'h0);
        acc(1'b0, OFS_STAT, 8'h00);
        chk(v[ST_START], 1'b1);
        chk({sda_oe, scl_oe}, 2'b10);
        acc(1'b1, OFS_FLAG, 8'h07);
        for (i = 0; i < 3; i++) begin
            b = 8'($urandom) & ((i == 0) ? 8'hfe : 8'hff);
            stretch <= (i == 1);
            send(b, i != 2);
        end
        stretch <= 1'b0;
        acc(1'b1, OFS_CTRL2, 8'h02);
        wait_flag(8'h02);
        rd(OFS_CTRL2, 32'h40);
        acc(1'b0, OFS_STAT, 8'h00);
        chk(v[ST_START], 1'b1);
        chk({sda_oe, scl_oe}, 2'b10);
        acc(1'b1, OFS_FLAG, 8'h07);
        send(8'($urandom) | 8'h01, 1'b1);
        acc(1'b1, OFS_CTRL2, 8'h04);
        wait_flag(8'h02);
        acc(1'b0, OFS_STAT, 8'h00);
        chk(v[ST_STOP], 1'b1);
        rd(OFS_CTRL2, 32'h0);
        chk({sda_oe, scl_oe}, 2'b00);
        acc(1'b1, OFS_FLAG, 8'h07);
        jam_scl <= 1'b1;
        repeat (6) @(posedge CLK);
        acc(1'b1, OFS_CTRL2, 8'h01);
        wait_flag(8'h04);
        rd(OFS_CTRL2, 32'h0);
        chk({sda_oe, scl_oe}, 2'b00);
        jam_scl <= 1'b0;
        end_sim();
    end
endmodule : i2c_master_start_tx_brg_test

// ===== tb/i2c_slave_model.sv
`timescale 1ns/1ps
module i2c_slave_model (
    input  wire logic  clk,
    input  wire logic  scl,
    input  wire logic  sda,
    input  wire logic  ack_en,
    input  wire logic  stretch,
    output logic       sda_pull,
    output logic       scl_pull,
    output logic [7:0] got
);
    logic scl_q;
    logic sda_q;
    int   bitn;
    int   hold;
    initial begin
        sda_pull = 1'b0;
        scl_pull = 1'b0;
        got      = 8'h00;
        scl_q    = 1'b1;
        sda_q    = 1'b1;
        bitn     = 0;
        hold     = 0;
    end
    always @(posedge clk) begin
        scl_q    <= scl;
        sda_q    <= sda;
        hold     <= (hold > 0) ? hold - 1 : 0;
        scl_pull <= hold > 1;
        // Start or stop on the wire restarts framing
        if (scl && scl_q && sda != sda_q) bitn <= 0;
        if (!scl_q && scl && bitn < 9) begin
            bitn <= bitn + 1;
            if (bitn < 8) got <= {got[6:0], sda};
        end
        if (scl_q && !scl) begin
            if (stretch) hold <= 20;
            if (bitn == 8) sda_pull <= ack_en;
            if (bitn == 9) begin
                sda_pull <= 1'b0;
                bitn     <= 0;
            end
        end
    end
endmodule : i2c_slave_model
